// ===== src/eotg_regs.svh
// Purpose: register map, field positions, reset values, timing counts
// Assumes: AXI4-Lite with 32-bit data, one aligned word per register
// Notes: definitions only
`ifndef EOTG_REGS_SVH
`define EOTG_REGS_SVH
`define EOTG_ADDR_W 6
`define EOTG_OFF_CTRL 6'h00
`define EOTG_OFF_EXPOSURE 6'h04
`define EOTG_OFF_AOI 6'h08
`define EOTG_OFF_ROW 6'h0C
`define EOTG_OFF_OVH 6'h10
`define EOTG_OFF_RATE 6'h14
`define EOTG_OFF_LSEL 6'h18
`define EOTG_OFF_LSRC 6'h1C
`define EOTG_OFF_STATUS 6'h20
`define EOTG_OFF_FRAMES 6'h24
`define EOTG_OFF_IGNORED 6'h28
`define EOTG_CTRL_W 3
`define EOTG_CTRL_HW_EN 0
`define EOTG_CTRL_LEGACY 1
`define EOTG_CTRL_RATE_EN 2
`define EOTG_ST_W 4
`define EOTG_ST_EXPOSING 0
`define EOTG_ST_READING 1
`define EOTG_ST_READY 2
`define EOTG_ST_OVERLAP 3
`define EOTG_EXP_W 20
`define EOTG_AOI_W 12
`define EOTG_ROW_W 12
`define EOTG_OVH_W 16
`define EOTG_RATE_W 16
`define EOTG_SEL_W 2
`define EOTG_SRC_W 2
`define EOTG_CNT_W 28
`define EOTG_EVT_W 16
`define EOTG_SINCE_W 20
`define EOTG_PROD_W 36
`define EOTG_RST_CTRL 3'h1
`define EOTG_RST_EXPOSURE 20'h00064
`define EOTG_RST_AOI 12'h0FF
`define EOTG_RST_ROW 12'h010
`define EOTG_RST_OVH 16'h0100
`define EOTG_RST_RATE 16'h0000
`define EOTG_LINE_EXPOSURE 0
`define EOTG_LINE_READY 1
`define EOTG_PIN_FRAME 0
`define EOTG_PIN_ACQ 1
`define EOTG_CLK_PERIOD_NS 8
`define EOTG_TICK_NS 1000
`define EOTG_TICK_CYC (`EOTG_TICK_NS / `EOTG_CLK_PERIOD_NS)
`define EOTG_US_PER_S 1000000
`define EOTG_RESP_OKAY 2'h0
`define EOTG_RESP_SLVERR 2'h2
`endif

// ===== src/eotg_pkg.sv
// Purpose: shared types of the exposure trigger gate
// Assumes: nothing
// Notes: line source codes are software visible
package eotg_pkg;
  typedef enum logic [1:0] {
    eotg_src_off = 2'h0,
    eotg_src_exposure = 2'h1,
    eotg_src_ready = 2'h2
  } eotg_src_t;
  typedef enum logic [1:0] {
    eotg_st_idle = 2'b00,
    eotg_st_expose = 2'b01,
    eotg_st_stretch = 2'b10
  } eotg_acq_t;
endpackage

// ===== src/eotg_line_map.sv
// Purpose: per-line source selection for the physical output lines
// Assumes: sources come from flops on clk_sys
// Notes: one register stage per line
`timescale 1ns/1ps
module eotg_line_map
  import eotg_pkg::*;
#(
  parameter int N_LINES = 4
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire eotg_src_t [N_LINES-1:0] line_src,
  input wire logic exposure_active,
  input wire logic trigger_ready,
  output logic [N_LINES-1:0] line_out
);
  logic [N_LINES-1:0] line_d;

  function automatic logic pick(input eotg_src_t s, input logic e,
                                input logic r);
    case (s)
      eotg_src_exposure: pick = e;
      eotg_src_ready: pick = r;
      default: pick = 1'b0;
    endcase
  endfunction

  always_comb begin
    line_d = '0;
    for (int i = 0; i < N_LINES; i++) begin
      line_d[i] = pick(line_src[i], exposure_active, trigger_ready);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      line_out <= '0;
    end else begin
      line_out <= line_d;
    end
  end
endmodule

// ===== src/eotg_core.sv
// Purpose: overlapped exposure sequencing with trigger gating, monitors
//   and AXI4-Lite control
// Assumes: trigger pins asynchronous to clk_sys; exposure set in us
// Notes: readout length is (aoi height + 1) * row cycles + overhead
// Function
// - Overlap is implicit: a start during previous readout is overlapped.
// - No exposure starts while the previous exposure is still running.
// - Exposure never ends before the previous image readout is finished.
// - Triggers breaking overlap or readout limits are discarded and counted.
// - Exposure-active output goes high at exposure start, low at end.
// - Exposure-active edges lag exposure by fixed rise and fall delays.
// - After reset, output line 1 carries exposure-active; reconfigurable.
// - After reset, output line 2 carries trigger-ready; reconfigurable.
// - Routing: select line first, then write its source.
// - Ready qualifies frame trigger in standard, acquisition trigger legacy.
// - Ready rises when safe, falls at start, rises when next is safe.
// - Ready timing derives from exposure, area height and readout time.
// - Enabled rate limit keeps ready rises at most that many per second; here a rate of 0 sets no limit.
// - Rate above achievable leaves ready at the maximum-rate point.
// - Start attempts while ready is low produce no acquisition.
// - Ready is driven only while hardware triggering is enabled.
//
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "eotg_regs.svh"
module eotg_core
  import eotg_pkg::*;
#(
  parameter int N_LINES = 4,
  parameter int DLY_RISE = 2,
  parameter int DLY_FALL = 3
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [`EOTG_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`EOTG_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic frame_trig_in,
  input wire logic acq_trig_in,
  output logic exposure_active_out,
  output logic trigger_ready_out,
  output logic [N_LINES-1:0] line_out
);
  localparam int DL_W = 8;
  localparam int RISE_LAG = DLY_RISE + 1;
  localparam int FALL_LAG = DLY_FALL + 1;
  localparam int TICK_CYC = `EOTG_TICK_CYC;
  localparam int TICK_W = $clog2(TICK_CYC);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);
  localparam logic [TICK_W-1:0] TICK_ONE = 1;
  localparam logic [`EOTG_CNT_W-1:0] CNT_ONE = 1;
  localparam logic [`EOTG_EVT_W-1:0] EVT_ONE = 1;
  localparam logic [`EOTG_SINCE_W-1:0] SINCE_ONE = 1;
  localparam logic [`EOTG_PROD_W-1:0] ONE_SEC_US =
    `EOTG_PROD_W'(`EOTG_US_PER_S);

  if (N_LINES < 2 || N_LINES > 4 || DLY_RISE < 1 || DLY_FALL < 1 ||
      DLY_RISE > DL_W || DLY_FALL > DL_W) begin : g_bad_param
    $error("eotg_core: unsupported parameter values");
  end

  logic [1:0] pin_s1_q, pin_s2_q, pin_s3_q;
  logic edge_frame, edge_acq, trig_edge, start, exposing, rd_busy;
  logic safe_core, rate_lim, rate_ok, safe;
  logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d, wr_fire, wr_lsrc;
  logic [`EOTG_ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d, wv;
  logic [3:0] wstrb_q, wstrb_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [32:0] wr_old, rd_now;
  logic [`EOTG_CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [`EOTG_EXP_W-1:0] exp_us_q, exp_us_d;
  logic [`EOTG_AOI_W-1:0] aoi_q, aoi_d;
  logic [`EOTG_ROW_W-1:0] row_q, row_d;
  logic [`EOTG_OVH_W-1:0] ovh_q, ovh_d;
  logic [`EOTG_RATE_W-1:0] rate_q, rate_d;
  logic [`EOTG_SEL_W-1:0] lsel_q, lsel_d;
  eotg_src_t [N_LINES-1:0] src_q, src_d;
  eotg_src_t lsrc_wv;
  eotg_acq_t state_q, state_d;
  logic [`EOTG_CNT_W-1:0] exp_rem_q, exp_rem_d, rd_rem_q, rd_rem_d;
  logic [`EOTG_CNT_W-1:0] exp_cyc, rd_total;
  logic [`EOTG_SINCE_W-1:0] since_q, since_d;
  logic [`EOTG_PROD_W-1:0] rate_prod;
  logic [TICK_W-1:0] tick_q, tick_d;
  logic ready_q, ready_d, overlap_q, overlap_d, exp_act_q, exp_act_d;
  logic [`EOTG_EVT_W-1:0] frames_q, frames_d, ign_q, ign_d;
  logic [DL_W-1:0] dl_q, dl_d;
  logic [`EOTG_ST_W-1:0] status_v;

  // third stage feeds only the edge detector, never the first
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1_q <= 2'h0;
      pin_s2_q <= 2'h0;
      pin_s3_q <= 2'h0;
    end else begin
      pin_s1_q <= {acq_trig_in, frame_trig_in};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  assign edge_frame = pin_s2_q[`EOTG_PIN_FRAME] & ~pin_s3_q[`EOTG_PIN_FRAME];
  assign edge_acq = pin_s2_q[`EOTG_PIN_ACQ] & ~pin_s3_q[`EOTG_PIN_ACQ];
  assign trig_edge = ctrl_q[`EOTG_CTRL_LEGACY] ? edge_acq :
                     edge_frame;
  assign start = trig_edge & ready_q;
  assign exposing = (state_q != eotg_st_idle);
  assign rd_busy = (rd_rem_q != '0);

  assign exp_cyc = `EOTG_CNT_W'(32'(exp_us_q) * 32'(TICK_CYC));
  assign rd_total = `EOTG_CNT_W'((32'(aoi_q) + 32'h1) * 32'(row_q) +
                                 32'(ovh_q));
  assign rate_prod = `EOTG_PROD_W'(since_q) * `EOTG_PROD_W'(rate_q);
  assign rate_lim = ctrl_q[`EOTG_CTRL_RATE_EN] & (rate_q != '0);
  // a rate above the achievable one never binds, safe_core decides
  assign rate_ok = !rate_lim || (rate_prod >= ONE_SEC_US);
  // new exposure must not end before the running readout does
  assign safe_core = !exposing && (rd_rem_q <= exp_cyc);
  assign safe = ctrl_q[`EOTG_CTRL_HW_EN] & safe_core & rate_ok;

  always_comb begin
    status_v = '0;
    status_v[`EOTG_ST_EXPOSING] = exposing;
    status_v[`EOTG_ST_READING] = rd_busy;
    status_v[`EOTG_ST_READY] = ready_q;
    status_v[`EOTG_ST_OVERLAP] = overlap_q;
  end

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] st);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        merge[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
  endfunction

  // bit 32 flags an unmapped address
  function automatic logic [32:0] reg_read(input logic [`EOTG_ADDR_W-1:0] a);
    reg_read = 33'h000000000;
    case (a)
      `EOTG_OFF_CTRL: reg_read[31:0] = 32'(ctrl_q);
      `EOTG_OFF_EXPOSURE: reg_read[31:0] = 32'(exp_us_q);
      `EOTG_OFF_AOI: reg_read[31:0] = 32'(aoi_q);
      `EOTG_OFF_ROW: reg_read[31:0] = 32'(row_q);
      `EOTG_OFF_OVH: reg_read[31:0] = 32'(ovh_q);
      `EOTG_OFF_RATE: reg_read[31:0] = 32'(rate_q);
      `EOTG_OFF_LSEL: reg_read[31:0] = 32'(lsel_q);
      `EOTG_OFF_LSRC: begin
        if (32'(lsel_q) < N_LINES) begin
          reg_read[31:0] = 32'(src_q[lsel_q]);
        end
      end
      `EOTG_OFF_STATUS: reg_read[31:0] = 32'(status_v);
      `EOTG_OFF_FRAMES: reg_read[31:0] = 32'(frames_q);
      `EOTG_OFF_IGNORED: reg_read[31:0] = 32'(ign_q);
      default: reg_read[32] = 1'b1;
    endcase
  endfunction

  assign s_axi_awready = !aw_hold_q;
  assign s_axi_wready = !w_hold_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign wr_fire = aw_hold_q & w_hold_q & !bvalid_q;
  assign wr_old = reg_read(awaddr_q);
  assign rd_now = reg_read(s_axi_araddr);
  assign wv = merge(wr_old[31:0], wdata_q, wstrb_q);
  assign lsrc_wv = eotg_src_t'(wv[`EOTG_SRC_W-1:0]);
  assign wr_lsrc = wr_fire && (awaddr_q == `EOTG_OFF_LSRC) &&
                   (32'(lsel_q) < N_LINES);

  always_comb begin
    aw_hold_d = aw_hold_q;
    awaddr_d = awaddr_q;
    w_hold_d = w_hold_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = wr_old[32] ? `EOTG_RESP_SLVERR : `EOTG_RESP_OKAY;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rdata_d = rd_now[31:0];
      rresp_d = rd_now[32] ? `EOTG_RESP_SLVERR : `EOTG_RESP_OKAY;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      aw_hold_q <= 1'b0;
      awaddr_q <= '0;
      w_hold_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `EOTG_RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `EOTG_RESP_OKAY;
    end else begin
      aw_hold_q <= aw_hold_d;
      awaddr_q <= awaddr_d;
      w_hold_q <= w_hold_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  always_comb begin
    ctrl_d = ctrl_q;
    exp_us_d = exp_us_q;
    aoi_d = aoi_q;
    row_d = row_q;
    ovh_d = ovh_q;
    rate_d = rate_q;
    lsel_d = lsel_q;
    src_d = src_q;
    if (wr_fire) begin
      case (awaddr_q)
        `EOTG_OFF_CTRL: ctrl_d = wv[`EOTG_CTRL_W-1:0];
        `EOTG_OFF_EXPOSURE: exp_us_d = wv[`EOTG_EXP_W-1:0];
        `EOTG_OFF_AOI: aoi_d = wv[`EOTG_AOI_W-1:0];
        `EOTG_OFF_ROW: row_d = wv[`EOTG_ROW_W-1:0];
        `EOTG_OFF_OVH: ovh_d = wv[`EOTG_OVH_W-1:0];
        `EOTG_OFF_RATE: rate_d = wv[`EOTG_RATE_W-1:0];
        `EOTG_OFF_LSEL: lsel_d = wv[`EOTG_SEL_W-1:0];
        default: ;
      endcase
    end
    if (wr_lsrc) begin
      src_d[lsel_q] = lsrc_wv;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= `EOTG_RST_CTRL;
      exp_us_q <= `EOTG_RST_EXPOSURE;
      aoi_q <= `EOTG_RST_AOI;
      row_q <= `EOTG_RST_ROW;
      ovh_q <= `EOTG_RST_OVH;
      rate_q <= `EOTG_RST_RATE;
      lsel_q <= '0;
      for (int i = 0; i < N_LINES; i++) begin
        src_q[i] <= eotg_src_off;
      end
      src_q[`EOTG_LINE_EXPOSURE] <= eotg_src_exposure;
      src_q[`EOTG_LINE_READY] <= eotg_src_ready;
    end else begin
      ctrl_q <= ctrl_d;
      exp_us_q <= exp_us_d;
      aoi_q <= aoi_d;
      row_q <= row_d;
      ovh_q <= ovh_d;
      rate_q <= rate_d;
      lsel_q <= lsel_d;
      src_q <= src_d;
    end
  end

  always_comb begin
    state_d = state_q;
    exp_rem_d = exp_rem_q;
    rd_rem_d = rd_busy ? rd_rem_q - CNT_ONE : rd_rem_q;
    unique case (state_q)
      eotg_st_idle: begin
        if (start) begin
          state_d = eotg_st_expose;
          exp_rem_d = exp_cyc;
        end
      end
      eotg_st_expose: begin
        if (exp_rem_q != '0) begin
          exp_rem_d = exp_rem_q - CNT_ONE;
        end else if (rd_busy) begin
          state_d = eotg_st_stretch;
        end else begin
          state_d = eotg_st_idle;
          rd_rem_d = rd_total;
        end
      end
      eotg_st_stretch: begin
        if (!rd_busy) begin
          state_d = eotg_st_idle;
          rd_rem_d = rd_total;
        end
      end
      default: state_d = eotg_st_idle;
    endcase
    tick_d = (tick_q == TICK_LAST) ? '0 : tick_q + TICK_ONE;
    since_d = since_q;
    if (start) begin
      since_d = '0;
    end else if (tick_q == TICK_LAST && since_q != '1) begin
      since_d = since_q + SINCE_ONE;
    end
    ready_d = safe & !start;
    overlap_d = start ? rd_busy : overlap_q;
    frames_d = start ? frames_q + EVT_ONE : frames_q;
    ign_d = (trig_edge && !ready_q) ? ign_q + EVT_ONE : ign_q;
    dl_d = {dl_q[DL_W-2:0], exposing};
    // a pulse shorter than the delay skew still shows, cut to one cycle
    exp_act_d = exp_act_q ? dl_q[DLY_FALL-1] : dl_q[DLY_RISE-1];
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= eotg_st_idle;
      exp_rem_q <= '0;
      rd_rem_q <= '0;
      tick_q <= '0;
      since_q <= '0;
      ready_q <= 1'b0;
      overlap_q <= 1'b0;
      frames_q <= '0;
      ign_q <= '0;
      dl_q <= '0;
      exp_act_q <= 1'b0;
    end else begin
      state_q <= state_d;
      exp_rem_q <= exp_rem_d;
      rd_rem_q <= rd_rem_d;
      tick_q <= tick_d;
      since_q <= since_d;
      ready_q <= ready_d;
      overlap_q <= overlap_d;
      frames_q <= frames_d;
      ign_q <= ign_d;
      dl_q <= dl_d;
      exp_act_q <= exp_act_d;
    end
  end

  assign exposure_active_out = exp_act_q;
  assign trigger_ready_out = ready_q;

  eotg_line_map #(
    .N_LINES(N_LINES)
  ) u_line_map (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .line_src(src_q),
    .exposure_active(exp_act_q),
    .trigger_ready(ready_q),
    .line_out(line_out)
  );

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  overlap_flag_a: assert property (
    start |=> overlap_q == $past(rd_busy)) else $error("overlap flag wrong");
  no_restart_a: assert property (
    exposing |-> !ready_q && !start) else $error("start during exposure");
  end_wait_a: assert property (
    $fell(exposing) |-> $past(rd_rem_q) == '0 && rd_rem_q == $past(rd_total))
    else $error("exposure ended during readout");
  ign_count_a: assert property (
    trig_edge && !ready_q |=> ign_q == $past(ign_q) + EVT_ONE)
    else $error("discarded trigger not counted");
  no_acq_a: assert property (
    trig_edge && !ready_q |=> !$rose(exposing))
    else $error("acquisition from refused trigger");
  act_rise_a: assert property (
    $rose(exposing) |-> ##RISE_LAG exp_act_q)
    else $error("exposure active rise late");
  act_fall_a: assert property (
    $fell(exposing) |-> ##FALL_LAG !exp_act_q)
    else $error("exposure active fall late");
  route_reset_a: assert property (disable iff (1'b0)
    $rose(arst_n) |-> src_q[`EOTG_LINE_EXPOSURE] == eotg_src_exposure &&
                      src_q[`EOTG_LINE_READY] == eotg_src_ready)
    else $error("default line routing wrong");
  route_write_a: assert property (
    wr_lsrc |=> src_q[lsel_q] == $past(lsrc_wv))
    else $error("line source write lost");
  mode_source_a: assert property (
    start |-> (ctrl_q[`EOTG_CTRL_LEGACY] ? edge_acq : edge_frame))
    else $error("wrong trigger qualified");
  ready_drop_a: assert property (
    start |=> !ready_q ##1 !ready_q) else $error("ready stayed high");
  ready_safe_a: assert property (
    ready_q |-> rd_rem_q <= $past(exp_cyc))
    else $error("ready before readout fits");
  rate_limit_a: assert property (
    $rose(ready_q) && $past(rate_lim) |-> $past(rate_prod) >= ONE_SEC_US)
    else $error("ready faster than rate limit");
  hw_gate_a: assert property (
    !ctrl_q[`EOTG_CTRL_HW_EN] |=> !ready_q)
    else $error("ready without hardware trigger");

  overlap_start_c: cover property (start && rd_busy);
  stretch_c: cover property (state_q == eotg_st_stretch);
  refused_c: cover property (trig_edge && !ready_q);
  rate_hold_c: cover property (safe_core && !rate_ok ##1 rate_ok);
endmodule

// ===== verif/eotg_trig_src.sv
// Purpose: external trigger source model for the trigger pins
// Assumes: pins are driven push-pull and idle low between pulses
// Notes: prompt mode waits for trigger ready, otherwise fires blind
`timescale 1ns/1ps
module eotg_trig_src (
  input wire logic clk_sys,
  input wire logic go,
  input wire logic use_acq,
  input wire logic prompt,
  input wire logic trigger_ready_out,
  output logic frame_trig_in,
  output logic acq_trig_in,
  output logic busy
);
  logic armed = 1'h0;
  logic [2:0] cnt = 3'h0;
  // blind mode exists only to provoke the ignore path
  always @(posedge clk_sys) begin
    if (go)
      armed <= 1'h1;
    if (armed && (!prompt || trigger_ready_out)) begin
      armed <= 1'h0;
      cnt <= 3'h6;
    end else if (cnt != 3'h0)
      cnt <= cnt - 3'h1;
  end
  // four cycles high, two low, so the synchroniser sees a clean edge
  assign frame_trig_in = (cnt > 3'h2) && !use_acq;
  assign acq_trig_in = (cnt > 3'h2) && use_acq;
  assign busy = armed || go || (cnt != 3'h0);
endmodule

// ===== verif/exposure_overlap_trigger_gate_tb.sv
// Purpose: self-checking bench for the exposure trigger gate
// Assumes: AXI4-Lite master tasks, trigger model on the pins
// Notes: small exposure and readout values keep the run short
`timescale 1ns/1ps
`include "eotg_regs.svh"
module exposure_overlap_trigger_gate_tb
  import eotg_pkg::*;
;
  localparam int DR = 2;
  localparam int DF = 3;
  logic clk_sys = 1'h0;
  logic arst_n = 1'h0;
  logic [5:0] awaddr = 6'h0;
  logic [5:0] araddr = 6'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd;
  logic [3:0] line_out;
  logic frame_trig_in, acq_trig_in, exposure_active_out, trigger_ready_out;
  logic go = 1'h0, use_acq = 1'h0, prompt = 1'h0, busy;
  int bad_count = 0, num_checks = 0, cyc = 0, n, hi_n = 0, run = 0;

  always #4 clk_sys = ~clk_sys;

  eotg_core #(.N_LINES(4), .DLY_RISE(DR), .DLY_FALL(DF)) eotg_core_inst (
    .clk_sys(clk_sys), .arst_n(arst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .frame_trig_in(frame_trig_in),
    .acq_trig_in(acq_trig_in), .exposure_active_out(exposure_active_out),
    .trigger_ready_out(trigger_ready_out), .line_out(line_out));

  eotg_trig_src eotg_trig_src_inst (
    .clk_sys(clk_sys), .go(go), .use_acq(use_acq), .prompt(prompt),
    .trigger_ready_out(trigger_ready_out), .frame_trig_in(frame_trig_in),
    .acq_trig_in(acq_trig_in), .busy(busy));

  // width of the latest exposure-active pulse, in cycles
  always @(posedge clk_sys) begin
    hi_n <= exposure_active_out ? hi_n + 1 : 0;
    if (exposure_active_out)
      run <= hi_n + 1;
  end

  task chk(input string what, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  task tick(input int k);
    repeat (k) @(posedge clk_sys);
  endtask

  task wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h0;
    rsp = bresp;
  endtask

  task rdr(input logic [5:0] a);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rready <= 1'h0;
    rd = rdata;
    rsp = rresp;
  endtask

  task rchk(input string what, input logic [5:0] a, input logic [31:0] e);
    rdr(a);
    chk(what, e, rd);
  endtask

  task fire(input logic acq, input logic p);
    while (busy) @(posedge clk_sys);
    @(posedge clk_sys);
    use_acq <= acq;
    prompt <= p;
    go <= 1'h1;
    @(posedge clk_sys);
    go <= 1'h0;
  endtask

  // cycles from the fall of trigger ready to its next rise
  task gap;
    while (trigger_ready_out) @(posedge clk_sys);
    n = 0;
    while (!trigger_ready_out) begin
      n++;
      @(posedge clk_sys);
    end
  endtask

  task summarize;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // whole run needs under 35000 cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      summarize();
    end
  end

  initial begin
    tick(3);
    arst_n <= 1'h1;
    rchk("ctrl", `EOTG_OFF_CTRL, 32'h1);
    rchk("exposure", `EOTG_OFF_EXPOSURE, 32'h64);
    rchk("aoi", `EOTG_OFF_AOI, 32'hFF);
    rchk("row", `EOTG_OFF_ROW, 32'h10);
    rchk("ovh", `EOTG_OFF_OVH, 32'h100);
    rchk("rate", `EOTG_OFF_RATE, 32'h0);
    chk("ready", 32'h1, trigger_ready_out);
    chk("line2", 32'h1, line_out[1]);
    chk("line4", 32'h0, line_out[3]);
    wr(`EOTG_OFF_LSEL, 32'h0);
    rchk("src1", `EOTG_OFF_LSRC, eotg_src_exposure);
    wr(`EOTG_OFF_LSEL, 32'h1);
    rchk("src2", `EOTG_OFF_LSRC, eotg_src_ready);
    wr(`EOTG_OFF_LSEL, 32'h2);
    wr(`EOTG_OFF_LSRC, eotg_src_exposure);
    rchk("unmapped", 6'h2C, 32'h0);
    chk("rresp", `EOTG_RESP_SLVERR, rsp);
    wr(6'h30, 32'h5);
    chk("bresp", `EOTG_RESP_SLVERR, rsp);
    $display("registers done");
    wr(`EOTG_OFF_EXPOSURE, 32'h1);
    wr(`EOTG_OFF_AOI, 32'h3);
    wr(`EOTG_OFF_ROW, 32'h4);
    wr(`EOTG_OFF_OVH, 32'h8);
    fire(1'h0, 1'h1);
    while (trigger_ready_out) @(posedge clk_sys);
    fire(1'h0, 1'h0);
    tick(2);
    chk("line1", 32'h1, line_out[0]);
    chk("line3", 32'h1, line_out[2]);
    chk("line2 low", 32'h0, line_out[1]);
    while (exposure_active_out) @(posedge clk_sys);
    chk("width", 126 + DF - DR, run);
    while (!trigger_ready_out) @(posedge clk_sys);
    rchk("frames", `EOTG_OFF_FRAMES, 32'h1);
    rchk("ignored", `EOTG_OFF_IGNORED, 32'h1);
    $display("single frame done");
    // readout now 16*16+8 = 264 cycles, longer than the exposure
    wr(`EOTG_OFF_AOI, 32'hF);
    wr(`EOTG_OFF_ROW, 32'h10);
    fire(1'h0, 1'h1);
    gap();
    chk("ready gap", 32'h1, n >= 262 && n <= 270);
    fire(1'h0, 1'h1);
    while (busy) @(posedge clk_sys);
    rchk("overlap", `EOTG_OFF_STATUS, 32'hB);
    // drain exposure and its readout, or the next start overlaps again
    do rdr(`EOTG_OFF_STATUS); while (rd[1:0] != 2'h0);
    fire(1'h0, 1'h1);
    while (busy) @(posedge clk_sys);
    rchk("no overlap", `EOTG_OFF_STATUS, 32'h1);
    while (!trigger_ready_out) @(posedge clk_sys);
    $display("overlap done");
    wr(`EOTG_OFF_CTRL, 32'h0);
    tick(2);
    chk("ready off", 32'h0, trigger_ready_out);
    fire(1'h0, 1'h0);
    tick(8);
    rchk("frames off", `EOTG_OFF_FRAMES, 32'h4);
    wr(`EOTG_OFF_CTRL, 32'h3);
    fire(1'h0, 1'h0);
    tick(8);
    rchk("frames leg", `EOTG_OFF_FRAMES, 32'h4);
    fire(1'h1, 1'h1);
    tick(8);
    rchk("frames acq", `EOTG_OFF_FRAMES, 32'h5);
    $display("modes done");
    wr(`EOTG_OFF_AOI, 32'h3);
    wr(`EOTG_OFF_ROW, 32'h4);
    // 10000 per second: 100 us, 12500 cycles between rises
    wr(`EOTG_OFF_RATE, 32'h2710);
    wr(`EOTG_OFF_CTRL, 32'h5);
    while (!trigger_ready_out) @(posedge clk_sys);
    fire(1'h0, 1'h1);
    gap();
    chk("rate gap", 32'h1, n >= 12370 && n <= 12760);
    // limit above what a 20 us exposure allows: exposure sets the pace
    wr(`EOTG_OFF_EXPOSURE, 32'h14);
    wr(`EOTG_OFF_RATE, 32'hFFFF);
    fire(1'h0, 1'h1);
    gap();
    chk("fast rate gap", 32'h1, n >= 2500 && n <= 2510);
    $display("rate done");
    summarize();
  end
endmodule
